// [inc/ssi_pkg.sv]
// ----------------------------------------------------------------
// Shared constants for the rear start/stop interlock controller
// ----------------------------------------------------------------
package ssi_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned TICK_PERIOD_NS = 1_000_000;
    // Cycles per millisecond tick, 125000 at 125 MHz
    localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int unsigned TICK_CNT_W = 17;
    // Least closure time on the start and stop contacts
    localparam int unsigned CLOSE_MIN_MS = 1;
    // Two tick samples in a row guarantee a full millisecond of closure
    localparam logic [1:0] CLOSE_HOLD_TICKS = 2'(CLOSE_MIN_MS + 1);

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_CMD = 12'h004;
    localparam logic [11:0] ADDR_TEST_MS = 12'h008;
    localparam logic [11:0] ADDR_STATUS = 12'h00C;

    // Control register fields
    localparam int unsigned CTRL_SRC_REAR_BIT = 0;
    localparam int unsigned CTRL_ILK_EN_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;

    // Command register fields (write-only, self clearing)
    localparam int unsigned CMD_ARM_BIT = 0;
    localparam int unsigned CMD_START_BIT = 1;
    localparam int unsigned CMD_STOP_BIT = 2;
    localparam int unsigned CMD_FAIL_BIT = 3;

    // Test duration in milliseconds
    localparam int unsigned TEST_MS_W = 16;
    localparam logic [15:0] TEST_MS_RESET = 16'h03E8;

    // Status register fields
    localparam int unsigned STAT_STATE_LSB = 0;
    localparam int unsigned STAT_LOOP_BIT = 3;
    localparam int unsigned STAT_START_BIT = 4;
    localparam int unsigned STAT_STOP_BIT = 5;
    localparam int unsigned STAT_FPSTOP_BIT = 6;
    localparam int unsigned STAT_REFUSED_BIT = 7;

    // Status line positions
    localparam int unsigned OUT_READY = 0;
    localparam int unsigned OUT_RUN = 1;
    localparam int unsigned OUT_PASS = 2;
    localparam int unsigned OUT_FAIL = 3;
    localparam int unsigned OUT_ABORT = 4;
    localparam int unsigned OUT_W = 5;

    // Test sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_READY,
        ST_RUN,
        ST_PASS,
        ST_FAIL,
        ST_ABORT
    } ssi_state_t;

endpackage

// [verilog/ssi_contact.sv]
// ----------------------------------------------------------------
// Contact closure qualifier: sync, glitch reject, tick hold
// ----------------------------------------------------------------
module ssi_contact (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    // Millisecond tick from the owner
    input wire logic tick_in,
    // Contact pin, low when closed to its return
    input wire logic pin_n_in,
    // Qualified closure level and its rising pulse
    output logic closed_out,
    output logic press_out
);

    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic open_reg;
    logic [1:0] hold_reg;
    logic closed_reg;

    // Three stage synchroniser; first stage feeds only the second
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            s3_reg <= 1'b1;
        end else begin
            s1_reg <= pin_n_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // A change counts only once stages two and three agree
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            open_reg <= 1'b1;
        end else if (s2_reg == s3_reg) begin
            open_reg <= s2_reg;
        end
    end

    // Count tick samples of continuous closure; any opening restarts it
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            hold_reg <= 2'h0;
        end else if (open_reg) begin
            hold_reg <= 2'h0;
        end else if (tick_in && hold_reg != ssi_pkg::CLOSE_HOLD_TICKS) begin
            hold_reg <= hold_reg + 2'h1;
        end
    end

    // Closed only after the hold is reached, open at once on release
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            closed_reg <= 1'b0;
        end else begin
            closed_reg <= !open_reg && hold_reg == ssi_pkg::CLOSE_HOLD_TICKS;
        end
    end

    assign closed_out = closed_reg;
    // Pulse on the first cycle the closure is qualified
    assign press_out = !closed_reg && !open_reg && hold_reg == ssi_pkg::CLOSE_HOLD_TICKS;

endmodule

// [verilog/ssi_ctrl.sv]
// Overview of operation
// - Interlock on: start only with loop shorted
// - Rear start and stop act only when rear selected
// - Stop closure of 1ms arms ready state
// - Start closure of 1ms begins test
// - Stop closure during test stops it
// - Front panel stop always stops test
// - Interlock off: loop state ignored
// - Drive status lines for outside party
module ssi_ctrl #(
    parameter int unsigned TICK_CYCLES = ssi_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    // APB slave
    input wire logic [11:0] paddr_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Rear port contacts, low when closed to input_return
    input wire logic start_pin_n_in,
    input wire logic stop_pin_n_in,
    input wire logic safety_loop_b_n_in,
    // Front panel stop key, low while pressed
    input wire logic fp_stop_n_in,
    // Rear port drives
    output logic safety_loop_a_out,
    output logic [4:0] status_lines_out
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [ssi_pkg::TICK_CNT_W-1:0] tick_cnt_reg;
    logic tick_reg;
    logic start_closed;
    logic start_press;
    logic stop_closed;
    logic stop_press;
    logic loop_closed;
    logic fp_closed;
    logic fp_press;
    logic [1:0] ctrl_reg;
    logic [15:0] test_ms_reg;
    logic [15:0] run_ms_reg;
    logic cmd_arm_reg;
    logic cmd_start_reg;
    logic cmd_stop_reg;
    logic cmd_fail_reg;
    logic refused_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic loop_a_reg;
    logic [4:0] lines_reg;
    logic [4:0] lines_next;
    ssi_pkg::ssi_state_t state_reg;
    ssi_pkg::ssi_state_t state_next;
    logic src_rear;
    logic ilk_en;
    logic ilk_ok;
    logic arm_req;
    logic start_req;
    logic stop_req;
    logic ilk_trip;
    logic refuse_evt;
    logic setup_ph;
    logic wr_acc;
    logic [31:0] rd_word;
    logic rd_hit;

    // ------------------------------------------------------------
    // Millisecond tick
    // ------------------------------------------------------------

    // Free running divider; one-cycle tick every millisecond
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            tick_cnt_reg <= '0;
            tick_reg <= 1'b0;
        end else if (tick_cnt_reg == ssi_pkg::TICK_CNT_W'(TICK_CYCLES - 1)) begin
            tick_cnt_reg <= '0;
            tick_reg <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + ssi_pkg::TICK_CNT_W'(1);
            tick_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Contact qualifiers
    // ------------------------------------------------------------

    ssi_contact u_start (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .tick_in(tick_reg),
        .pin_n_in(start_pin_n_in),
        .closed_out(start_closed),
        .press_out(start_press)
    );

    ssi_contact u_stop (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .tick_in(tick_reg),
        .pin_n_in(stop_pin_n_in),
        .closed_out(stop_closed),
        .press_out(stop_press)
    );

    // Loop read back: loop_a is held low, so a short pulls loop_b low
    ssi_contact u_loop (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .tick_in(tick_reg),
        .pin_n_in(safety_loop_b_n_in),
        .closed_out(loop_closed),
        .press_out()
    );

    ssi_contact u_fpstop (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .tick_in(tick_reg),
        .pin_n_in(fp_stop_n_in),
        .closed_out(fp_closed),
        .press_out(fp_press)
    );

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------

    // Source select gates the rear contacts and the arm, start and stop commands apart
    assign src_rear = ctrl_reg[ssi_pkg::CTRL_SRC_REAR_BIT];
    assign ilk_en = ctrl_reg[ssi_pkg::CTRL_ILK_EN_BIT];
    // With the interlock off the loop is not consulted at all
    assign ilk_ok = !ilk_en || loop_closed;
    assign arm_req = src_rear ? stop_press : cmd_arm_reg;
    assign start_req = src_rear ? start_press : cmd_start_reg;
    // Front key is honoured whatever the source
    assign stop_req = (src_rear ? stop_press : cmd_stop_reg) || fp_press;
    // Relies on the fixture holding the loop shut for the whole test
    assign ilk_trip = ilk_en && !loop_closed;
    assign refuse_evt = state_reg == ssi_pkg::ST_READY && start_req && !ilk_ok;

    // ------------------------------------------------------------
    // Test sequencer
    // ------------------------------------------------------------

    // Front key outranks a start, and any stop outranks a fail or a finish, seen in the same cycle
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ssi_pkg::ST_READY: begin
                if (fp_press) begin
                    state_next = ssi_pkg::ST_IDLE;
                end else if (start_req && ilk_ok) begin
                    state_next = ssi_pkg::ST_RUN;
                end
            end
            ssi_pkg::ST_RUN: begin
                if (stop_req) begin
                    state_next = ssi_pkg::ST_ABORT;
                end else if (ilk_trip) begin
                    state_next = ssi_pkg::ST_ABORT;
                end else if (cmd_fail_reg) begin
                    state_next = ssi_pkg::ST_FAIL;
                end else if (run_ms_reg >= test_ms_reg) begin
                    state_next = ssi_pkg::ST_PASS;
                end
            end
            ssi_pkg::ST_IDLE,
            ssi_pkg::ST_PASS,
            ssi_pkg::ST_FAIL,
            ssi_pkg::ST_ABORT: begin
                if (arm_req) begin
                    state_next = ssi_pkg::ST_READY;
                end
            end
            default: begin
                state_next = ssi_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            state_reg <= ssi_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Elapsed test time in ms; cleared on entry, saturates at the top
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            run_ms_reg <= 16'h0000;
        end else if (state_reg != ssi_pkg::ST_RUN) begin
            run_ms_reg <= 16'h0000;
        end else if (tick_reg && run_ms_reg != 16'hFFFF) begin
            run_ms_reg <= run_ms_reg + 16'h0001;
        end
    end

    // Sticky record of a start refused by an open loop; set beats clear
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            refused_reg <= 1'b0;
        end else if (refuse_evt) begin
            refused_reg <= 1'b1;
        end else if (wr_acc && paddr_in == ssi_pkg::ADDR_STATUS
                     && pwdata_in[ssi_pkg::STAT_REFUSED_BIT]) begin
            refused_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Rear port outputs
    // ------------------------------------------------------------

    // One line per outcome so a fixture needs no decoding
    always_comb begin
        lines_next = 5'h00;
        lines_next[ssi_pkg::OUT_READY] = state_reg == ssi_pkg::ST_READY;
        lines_next[ssi_pkg::OUT_RUN] = state_reg == ssi_pkg::ST_RUN;
        lines_next[ssi_pkg::OUT_PASS] = state_reg == ssi_pkg::ST_PASS;
        lines_next[ssi_pkg::OUT_FAIL] = state_reg == ssi_pkg::ST_FAIL;
        lines_next[ssi_pkg::OUT_ABORT] = state_reg == ssi_pkg::ST_ABORT;
    end

    // Registered so the pins never glitch on state decode
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            lines_reg <= 5'h00;
            loop_a_reg <= 1'b1;
        end else begin
            lines_reg <= lines_next;
            loop_a_reg <= 1'b0;
        end
    end

    assign status_lines_out = lines_reg;
    assign safety_loop_a_out = loop_a_reg;

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------

    assign setup_ph = psel_in && !penable_in;
    assign wr_acc = psel_in && penable_in && pready_reg && pwrite_in && !pslverr_reg;

    // Read mux; the command register reads back as zero
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        case (paddr_in)
            ssi_pkg::ADDR_CTRL: begin
                rd_word[1:0] = ctrl_reg;
            end
            ssi_pkg::ADDR_CMD: begin
                rd_word = 32'h0000_0000;
            end
            ssi_pkg::ADDR_TEST_MS: begin
                rd_word[15:0] = test_ms_reg;
            end
            ssi_pkg::ADDR_STATUS: begin
                rd_word[ssi_pkg::STAT_STATE_LSB +: 3] = state_reg;
                rd_word[ssi_pkg::STAT_LOOP_BIT] = loop_closed;
                rd_word[ssi_pkg::STAT_START_BIT] = start_closed;
                rd_word[ssi_pkg::STAT_STOP_BIT] = stop_closed;
                rd_word[ssi_pkg::STAT_FPSTOP_BIT] = fp_closed;
                rd_word[ssi_pkg::STAT_REFUSED_BIT] = refused_reg;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // Answer is decided in setup so the access phase ends in one cycle
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else if (setup_ph) begin
            pready_reg <= 1'b1;
            pslverr_reg <= !rd_hit;
            prdata_reg <= pwrite_in ? 32'h0000_0000 : rd_word;
        end else begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end
    end

    assign prdata_out = prdata_reg;
    assign pready_out = pready_reg;
    assign pslverr_out = pslverr_reg;

    // Configuration registers
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            ctrl_reg <= ssi_pkg::CTRL_RESET;
            test_ms_reg <= ssi_pkg::TEST_MS_RESET;
        end else if (wr_acc && paddr_in == ssi_pkg::ADDR_CTRL) begin
            ctrl_reg <= pwdata_in[1:0];
        end else if (wr_acc && paddr_in == ssi_pkg::ADDR_TEST_MS) begin
            test_ms_reg <= pwdata_in[15:0];
        end
    end

    // Command strobes live for one cycle; all but fail ignored while rear selected
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            cmd_arm_reg <= 1'b0;
            cmd_start_reg <= 1'b0;
            cmd_stop_reg <= 1'b0;
            cmd_fail_reg <= 1'b0;
        end else if (wr_acc && paddr_in == ssi_pkg::ADDR_CMD) begin
            cmd_arm_reg <= pwdata_in[ssi_pkg::CMD_ARM_BIT];
            cmd_start_reg <= pwdata_in[ssi_pkg::CMD_START_BIT];
            cmd_stop_reg <= pwdata_in[ssi_pkg::CMD_STOP_BIT];
            cmd_fail_reg <= pwdata_in[ssi_pkg::CMD_FAIL_BIT];
        end else begin
            cmd_arm_reg <= 1'b0;
            cmd_start_reg <= 1'b0;
            cmd_stop_reg <= 1'b0;
            cmd_fail_reg <= 1'b0;
        end
    end

endmodule

// [bench/ssi_ctrl_sva.sv]
// ------------------------------------------------------------
// Port checker for the start/stop interlock controller
// ------------------------------------------------------------
module ssi_ctrl_sva #(
    parameter int unsigned TICK_CYCLES = 20
) (
    // Clock, reset and bus
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic [11:0] paddr_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    // Rear port, front key and status
    input wire logic start_pin_n_in,
    input wire logic stop_pin_n_in,
    input wire logic safety_loop_b_n_in,
    input wire logic fp_stop_n_in,
    input wire logic safety_loop_a_out,
    input wire logic [4:0] status_lines_out
);
    // Two ticks of qualification plus sync, with margin
    localparam int QMAX = 3 * TICK_CYCLES + 8;
    logic src_rear_reg;
    logic ilk_en_reg;
    logic [3:0] cmd_age_reg;
    logic wr_done;
    logic run_s;
    logic rdy_s;
    logic abt_s;
    assign wr_done = psel_in && penable_in && pready_out && pwrite_in;
    assign run_s = status_lines_out[ssi_pkg::OUT_RUN];
    assign rdy_s = status_lines_out[ssi_pkg::OUT_READY];
    assign abt_s = status_lines_out[ssi_pkg::OUT_ABORT];
    // Shadow of the control bits, since the checker cannot see inside
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            src_rear_reg <= 1'b0;
            ilk_en_reg <= 1'b0;
        end else if (wr_done && paddr_in == ssi_pkg::ADDR_CTRL) begin
            src_rear_reg <= pwdata_in[ssi_pkg::CTRL_SRC_REAR_BIT];
            ilk_en_reg <= pwdata_in[ssi_pkg::CTRL_ILK_EN_BIT];
        end
    end
    // Age of the last command write, saturating so it never wraps
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            cmd_age_reg <= 4'hF;
        end else if (wr_done && paddr_in == ssi_pkg::ADDR_CMD) begin
            cmd_age_reg <= 4'h0;
        end else if (cmd_age_reg != 4'hF) begin
            cmd_age_reg <= cmd_age_reg + 4'h1;
        end
    end
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    bus_answer_a: assert property (psel_in && !penable_in |=> pready_out)
        else $error("no answer after setup");
    loop_drive_a: assert property (!sys_rst_in ##1 !sys_rst_in |-> !safety_loop_a_out)
        else $error("loop drive not low");
    lines_onehot_a: assert property ($onehot0(status_lines_out))
        else $error("status lines not one hot");
    loop_gate_a: assert property ($rose(run_s) && ilk_en_reg |-> !$past(safety_loop_b_n_in, 2))
        else $error("start with loop open");
    front_start_a: assert property ($rose(run_s) && !src_rear_reg |-> cmd_age_reg < 4'h8)
        else $error("front start without command");
    rear_start_a: assert property ($rose(run_s) && src_rear_reg |-> !$past(start_pin_n_in, 20))
        else $error("rear start without held closure");
    rear_arm_a: assert property ($rose(rdy_s) && src_rear_reg |-> !$past(stop_pin_n_in, 20))
        else $error("ready without held stop");
    stop_abort_a: assert property ((src_rear_reg && run_s && !stop_pin_n_in)[*8] |-> ##[1:QMAX] abt_s)
        else $error("stop closure ignored in run");
    key_abort_a: assert property ((run_s && !fp_stop_n_in)[*8] |-> ##[1:QMAX] abt_s)
        else $error("front key ignored in run");
    loop_trip_a: assert property (ilk_en_reg && run_s && safety_loop_b_n_in |-> ##[1:12] abt_s)
        else $error("open loop did not abort");
    cover property ($rose(status_lines_out[ssi_pkg::OUT_PASS]));
    cover property ($rose(abt_s));
    cover property (pslverr_out);
endmodule

bind ssi_ctrl ssi_ctrl_sva #(.TICK_CYCLES(TICK_CYCLES)) ssi_ctrl_sva_i (.*);

// [bench/ssi_fixture.sv]
// ------------------------------------------------------------
// Outside fixture: contacts to input_return and the loop key
// ------------------------------------------------------------
module ssi_fixture (
    // Clock
    input wire logic ref_clk_in,
    // Loop drive from the device
    input wire logic safety_loop_a_in,
    // Contacts toward the device, pulled up when open
    output logic start_pin_n_out,
    output logic stop_pin_n_out,
    output logic safety_loop_b_n_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic loop_shut = 1'b0;
    // Contacts rest open
    initial begin
        start_pin_n_out = 1'b1;
        stop_pin_n_out = 1'b1;
    end
    // An open loop floats to the pull-up, a shorted one follows the drive
    assign safety_loop_b_n_out = loop_shut ? safety_loop_a_in : 1'b1;
    // Close one contact for some clocks, then reopen so a new press can follow
    task automatic press(input logic is_start, input int unsigned cyc);
        @(posedge ref_clk_in);
        if (is_start) start_pin_n_out <= 1'b0;
        else stop_pin_n_out <= 1'b0;
        repeat (cyc) @(posedge ref_clk_in);
        start_pin_n_out <= 1'b1;
        stop_pin_n_out <= 1'b1;
    endtask
    // Loop key in or out; kept in for a whole test unless a trip is wanted
    task automatic set_loop(input logic shut);
        @(posedge ref_clk_in);
        loop_shut <= shut;
    endtask
endmodule

// [bench/ssi_ctrl_tb.sv]
`define CHK(nm, e, a) begin check_count++; if ((a) !== (e)) begin err_count++; \
    $display("wrong value %s expected %h seen %h", nm, e, a); end end
// ------------------------------------------------------------
// Bench for the start/stop interlock controller
// ------------------------------------------------------------
module ssi_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [31:0] d; logic [31:0] m; logic e; logic [4:0] s;} ssi_note_t;
    logic ref_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [11:0] paddr_in = 12'h000;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [31:0] pwdata_in = 32'h0000_0000;
    logic fp_stop_n_in = 1'b1;
    logic [31:0] prdata_out;
    logic pready_out;
    logic pslverr_out;
    logic start_pin_n_in;
    logic stop_pin_n_in;
    logic safety_loop_b_n_in;
    logic safety_loop_a_out;
    logic [4:0] status_lines_out;
    logic [4:0] exp_s = 5'h00;
    int err_count = 0;
    int check_count = 0;
    ssi_note_t notes[$];
    ssi_note_t nt;
    // Short tick keeps every contact press to a few dozen clocks
    ssi_ctrl #(.TICK_CYCLES(20)) ssi_ctrl_i (.*);
    ssi_fixture ssi_fixture_i (.ref_clk_in(ref_clk_in), .safety_loop_a_in(safety_loop_a_out),
        .start_pin_n_out(start_pin_n_in), .stop_pin_n_out(stop_pin_n_in),
        .safety_loop_b_n_out(safety_loop_b_n_in));
    // 125 MHz clock
    initial begin
        forever #4 ref_clk_in = ~ref_clk_in;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask
    // One APB transfer; the note is judged by the monitor when pready shows
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
            input logic [31:0] ed, input logic [31:0] m, input logic ee);
        int n;
        n = 0;
        @(posedge ref_clk_in);
        notes.push_back('{ed, m, ee, exp_s});
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        paddr_in <= a;
        pwrite_in <= w;
        pwdata_in <= d;
        @(posedge ref_clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge ref_clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        `CHK("pready", 1'b1, pready_out)
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d, 32'h0000_0000, 32'h0000_0000, 1'b0);
    endtask
    // Status read after the lines have settled: state code and refused flag
    task automatic stat(input logic [2:0] code, input logic refd);
        cyc(4);
        xfer(ssi_pkg::ADDR_STATUS, 1'b0, 32'h0000_0000, {24'h00_0000, refd, 4'h0, code},
            32'h0000_0087, 1'b0);
    endtask
    // Hold a contact long enough to qualify, expect new lines and state
    task automatic hit(input logic s, input logic [4:0] e, input logic [2:0] code);
        ssi_fixture_i.press(s, 60 + $urandom_range(30));
        cyc(25);
        exp_s = e;
        stat(code, 1'b0);
    endtask
    // Each answered transfer is matched with the oldest note
    always @(posedge ref_clk_in) begin
        if (pready_out === 1'b1 && notes.size() > 0) begin
            nt = notes.pop_front();
            `CHK("prdata", nt.d, prdata_out & nt.m)
            `CHK("pslverr", nt.e, pslverr_out)
            `CHK("lines", nt.s, status_lines_out)
        end
    end
    task automatic summarize();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Hang guard, far beyond the few thousand clocks the tests need
    initial begin
        cyc(20000);
        err_count++;
        summarize();
    end
    initial begin
        void'($urandom(32'h124a_ab31));
        cyc(12);
        sys_rst_in <= 1'b0;
        xfer(ssi_pkg::ADDR_CTRL, 1'b0, 32'h0, 32'h0, 32'hFFFF_FFFF, 1'b0);
        xfer(ssi_pkg::ADDR_TEST_MS, 1'b0, 32'h0, 32'h0000_03E8, 32'hFFFF_FFFF, 1'b0);
        xfer(12'h010, 1'b1, $urandom, 32'h0, 32'h0, 1'b1);
        wr(ssi_pkg::ADDR_TEST_MS, 32'h0000_0008);
        hit(1'b0, 5'h00, 3'd0);
        wr(ssi_pkg::ADDR_CMD, 32'h0000_0001);
        exp_s = 5'h01;
        stat(3'd1, 1'b0);
        wr(ssi_pkg::ADDR_CMD, 32'h0000_0002);
        exp_s = 5'h02;
        stat(3'd2, 1'b0);
        wr(ssi_pkg::ADDR_CMD, 32'h0000_0008);
        exp_s = 5'h08;
        stat(3'd4, 1'b0);
        wr(ssi_pkg::ADDR_CMD, 32'h0000_0001);
        exp_s = 5'h01;
        wr(ssi_pkg::ADDR_CMD, 32'h0000_0002);
        exp_s = 5'h02;
        wr(ssi_pkg::ADDR_CMD, 32'h0000_0004);
        exp_s = 5'h10;
        stat(3'd5, 1'b0);
        wr(ssi_pkg::ADDR_CTRL, 32'h0000_0001);
        wr(ssi_pkg::ADDR_CMD, 32'h0000_0001);
        stat(3'd5, 1'b0);
        hit(1'b0, 5'h01, 3'd1);
        hit(1'b1, 5'h02, 3'd2);
        cyc(200);
        exp_s = 5'h04;
        stat(3'd3, 1'b0);
        wr(ssi_pkg::ADDR_TEST_MS, 32'h0000_0028);
        hit(1'b0, 5'h01, 3'd1);
        hit(1'b1, 5'h02, 3'd2);
        hit(1'b0, 5'h10, 3'd5);
        hit(1'b0, 5'h01, 3'd1);
        hit(1'b1, 5'h02, 3'd2);
        fp_stop_n_in <= 1'b0;
        cyc(80);
        fp_stop_n_in <= 1'b1;
        cyc(25);
        exp_s = 5'h10;
        stat(3'd5, 1'b0);
        wr(ssi_pkg::ADDR_CTRL, 32'h0000_0003);
        hit(1'b0, 5'h01, 3'd1);
        ssi_fixture_i.press(1'b1, 10);
        cyc(25);
        stat(3'd1, 1'b0);
        ssi_fixture_i.press(1'b1, 80);
        cyc(25);
        stat(3'd1, 1'b1);
        wr(ssi_pkg::ADDR_STATUS, 32'h0000_0080);
        stat(3'd1, 1'b0);
        ssi_fixture_i.set_loop(1'b1);
        cyc(60);
        hit(1'b1, 5'h02, 3'd2);
        ssi_fixture_i.set_loop(1'b0);
        cyc(20);
        exp_s = 5'h10;
        stat(3'd5, 1'b0);
        cyc(5);
        summarize();
    end
endmodule
